// file: les_lab.sv
`include "les_params.svh"
`default_nettype none

module les_lab (
  input  wire logic                                  clk_i,         // block clock
  input  wire logic                                  sys_rst_i,     // synchronous reset
  input  wire logic                                  aclr_i,        // block asynchronous clear
  input  wire les_pkg::les_ctrl_t                    ctrl_i,        // block-wide controls
  input  wire les_pkg::les_cfg_t  [`LES_NUM_LE-1:0]  cfg_i,         // per element configuration
  input  wire les_pkg::les_data_t [`LES_NUM_LE-1:0]  data_i,        // four data inputs per element
  input  wire logic                                  reg_chain_i,   // register chain from block above
  output var  logic               [`LES_NUM_LE-1:0]  comb_o,        // unregistered results
  output var  logic               [`LES_NUM_LE-1:0]  reg_o,         // registered results
  output var  logic                                  carry_out0_o,  // primary carry to next block
  output var  logic                                  carry_out1_o   // secondary carry to next block
);
  import les_pkg::*;

  // single lookup of a four input table, used by the element logic; checks index the mask directly
  function automatic logic lut_eval(input logic [`LES_LUT_W-1:0] mask,
                                    input logic [`LES_IN_W-1:0]  idx);
    lut_eval = mask[idx];
  endfunction

  function automatic logic maj3(input logic x, input logic y, input logic z);
    maj3 = (x & y) | (x & z) | (y & z);
  endfunction

  logic [`LES_NUM_LE:0]   cin0;
  logic [`LES_NUM_LE:0]   cin1;
  logic [`LES_NUM_LE:0]   rchain;
  logic [`LES_NUM_LE:0]   lchain;
  logic [`LES_NUM_LE-1:0] comb;
  logic [`LES_NUM_LE-1:0] q;
  logic [`LES_NUM_LE-1:0] reg_d;

  // carry-select pair: primary assumes block carry 0, secondary 1;
  // subtraction needs carry one into the lsb whatever the block carry
  assign cin0[0] = ctrl_i.sub ? `LES_SUB_CIN0 : `LES_ADD_CIN0;
  assign cin1[0] = `LES_CIN1;

  // top element has no element above on the lookup chain
  assign lchain[0] = `LES_CHAIN_TOP;
  assign rchain[0] = reg_chain_i;

  genvar gi;
  generate
    for (gi = 0; gi < `LES_NUM_LE; gi++) begin : g_le
      logic [`LES_IN_W-1:0] lin;
      logic                 b_eff;
      logic                 cin_sel;

      // route the four inputs per mode
      always_comb begin
        lin = data_i[gi];
        if (cfg_i[gi].mode == LES_MODE_NORMAL && cfg_i[gi].lut_chain_en && gi > 0) begin
          lin[`LES_IDX_C] = lchain[gi];
        end
        if (cfg_i[gi].mode == LES_MODE_NORMAL && cfg_i[gi].fb_en) begin
          lin[`LES_IDX_D] = q[gi];
        end
      end

      assign b_eff   = data_i[gi][`LES_IDX_B] ^ ctrl_i.sub;
      assign cin_sel = ctrl_i.lab_cin ? cin1[gi] : cin0[gi];

      // one enum bit, so the element is always in exactly one mode
      always_comb begin
        case (cfg_i[gi].mode)
          LES_MODE_ARITH: begin
            comb[gi] = data_i[gi][`LES_IDX_A] ^ b_eff ^ cin_sel;
          end
          default: begin
            comb[gi] = lut_eval(cfg_i[gi].lut_mask, lin);
          end
        endcase
      end

      // normal mode lets carries pass so arithmetic above and below can share a block
      always_comb begin
        if (cfg_i[gi].mode == LES_MODE_ARITH) begin
          cin0[gi+1] = maj3(data_i[gi][`LES_IDX_A], b_eff, cin0[gi]);
          cin1[gi+1] = maj3(data_i[gi][`LES_IDX_A], b_eff, cin1[gi]);
        end else begin
          cin0[gi+1] = cin0[gi];
          cin1[gi+1] = cin1[gi];
        end
      end

      assign lchain[gi+1] = comb[gi];

      // chained register leaves the table to an unrelated function
      assign reg_d[gi] = (cfg_i[gi].reg_src == LES_SRC_CHAIN) ? rchain[gi] : comb[gi];

      les_le_reg u_reg (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .aclr_i    (aclr_i),
        .en_i      (ctrl_i.clk_en),
        .d_i       (reg_d[gi]),
        .q_o       (q[gi])
      );

      assign rchain[gi+1] = q[gi];

      a_chain_shift : assert property (@(posedge clk_i)
        disable iff (sys_rst_i || aclr_i)
        ctrl_i.clk_en && cfg_i[gi].reg_src == LES_SRC_CHAIN |=> q[gi] == $past(rchain[gi]))
        else $error("register chain did not shift");

      a_lut_free_chain : assert property (@(posedge clk_i)
        disable iff (sys_rst_i || aclr_i)
        cfg_i[gi].reg_src == LES_SRC_CHAIN && cfg_i[gi].mode == LES_MODE_NORMAL
          && !cfg_i[gi].fb_en && !cfg_i[gi].lut_chain_en
        |-> comb[gi] == cfg_i[gi].lut_mask[data_i[gi]])
        else $error("lookup table disturbed by register chain");

      a_dual_outputs : assert property (@(posedge clk_i)
        disable iff (sys_rst_i || aclr_i)
        ctrl_i.clk_en && cfg_i[gi].reg_src == LES_SRC_LUT
        |=> reg_o[gi] == $past(comb_o[gi]))
        else $error("registered copy differs from combinatorial result");

      a_feedback_pack : assert property (@(posedge clk_i)
        disable iff (sys_rst_i || aclr_i)
        cfg_i[gi].mode == LES_MODE_NORMAL && cfg_i[gi].fb_en && !cfg_i[gi].lut_chain_en
        |-> comb[gi] == cfg_i[gi].lut_mask[{q[gi], data_i[gi][`LES_IDX_C:`LES_IDX_A]}])
        else $error("register feedback not seen by own table");

      if (gi > 0) begin : g_lchk
        a_lut_cascade : assert property (@(posedge clk_i)
          disable iff (sys_rst_i || aclr_i)
          cfg_i[gi].mode == LES_MODE_NORMAL && cfg_i[gi].lut_chain_en && !cfg_i[gi].fb_en
          |-> comb[gi] == cfg_i[gi].lut_mask[{data_i[gi][`LES_IDX_D], comb[gi-1],
                                               data_i[gi][`LES_IDX_B:`LES_IDX_A]}])
          else $error("lookup chain input not taken from element above");
      end
    end
  endgenerate

  // outputs: registered copy comes from the element flops, the
  // combinatorial copy cannot be registered without losing its purpose
  assign reg_o        = q;
  assign comb_o       = comb;
  assign carry_out0_o = cin0[`LES_NUM_LE];
  assign carry_out1_o = cin1[`LES_NUM_LE];

  // reference adder for whole-block arithmetic checks
  logic                   all_arith;
  logic [`LES_NUM_LE-1:0] a_vec;
  logic [`LES_NUM_LE-1:0] b_vec;
  logic [`LES_NUM_LE:0]   ref_sum;

  always_comb begin
    all_arith = 1'h1;
    a_vec     = '0;
    b_vec     = '0;
    for (int k = 0; k < `LES_NUM_LE; k++) begin
      all_arith = all_arith & (cfg_i[k].mode == LES_MODE_ARITH);
      a_vec[k]  = data_i[k][`LES_IDX_A];
      b_vec[k]  = data_i[k][`LES_IDX_B];
    end
    ref_sum = {1'h0, a_vec} + {1'h0, b_vec ^ {`LES_NUM_LE{ctrl_i.sub}}}
              + {{`LES_NUM_LE{1'h0}}, ctrl_i.sub | ctrl_i.lab_cin};
  end

  a_add_sub_block : assert property (@(posedge clk_i)
    disable iff (sys_rst_i || aclr_i)
    all_arith |-> comb_o == ref_sum[`LES_NUM_LE-1:0])
    else $error("block sum or difference wrong");

  a_sub_carry_out : assert property (@(posedge clk_i)
    disable iff (sys_rst_i || aclr_i)
    all_arith && ctrl_i.sub
    |-> (ctrl_i.lab_cin ? carry_out1_o : carry_out0_o) == ref_sum[`LES_NUM_LE])
    else $error("two's complement carry out wrong");

  a_first_carry : assert property (@(posedge clk_i)
    disable iff (sys_rst_i || aclr_i)
    ctrl_i.sub && cfg_i[0].mode == LES_MODE_ARITH
    |-> comb_o[0] == !(data_i[0][`LES_IDX_A] ^ !data_i[0][`LES_IDX_B]))
    else $error("lsb carry in not forced when subtracting");

  a_mode_normal : assert property (@(posedge clk_i)
    disable iff (sys_rst_i || aclr_i)
    cfg_i[0].mode == LES_MODE_NORMAL
    |-> comb_o[0] == cfg_i[0].lut_mask[{cfg_i[0].fb_en ? reg_o[0] : data_i[0][`LES_IDX_D],
                                          data_i[0][`LES_IDX_C:`LES_IDX_A]}])
    else $error("normal mode element not using its table");

  a_hold_no_enable : assert property (@(posedge clk_i)
    disable iff (sys_rst_i || aclr_i)
    !ctrl_i.clk_en |=> reg_o == $past(reg_o))
    else $error("registers changed without clock enable");

  a_sync_reset : assert property (@(posedge clk_i)
    $past(sys_rst_i) && !aclr_i |-> reg_o == '0)
    else $error("registers not zero after reset");

endmodule

`default_nettype wire

// file: les_params.svh
`ifndef LES_PARAMS_SVH
`define LES_PARAMS_SVH

// block geometry
`define LES_NUM_LE      10
`define LES_IN_W        4
`define LES_LUT_W       16

// data input positions inside one element
`define LES_IDX_A       0
`define LES_IDX_B       1
`define LES_IDX_C       2
`define LES_IDX_D       3

// register, carry and lookup chain constants
`define LES_REG_RST     1'h0
`define LES_ADD_CIN0    1'h0
`define LES_SUB_CIN0    1'h1
`define LES_CIN1        1'h1
`define LES_CHAIN_TOP   1'h0

`endif

// file: les_pkg.sv
`include "les_params.svh"
`default_nettype none

package les_pkg;

  typedef enum logic {
    LES_MODE_NORMAL,
    LES_MODE_ARITH
  } les_mode_t;

  typedef enum logic {
    LES_SRC_LUT,
    LES_SRC_CHAIN
  } les_src_t;

  // static configuration of one logic_element
  typedef struct packed {
    les_mode_t                 mode;
    logic [`LES_LUT_W-1:0]     lut_mask;
    les_src_t                  reg_src;
    logic                      fb_en;
    logic                      lut_chain_en;
  } les_cfg_t;

  // logic_array_block wide controls
  typedef struct packed {
    logic                      sub;
    logic                      lab_cin;
    logic                      clk_en;
  } les_ctrl_t;

  typedef logic [`LES_IN_W-1:0] les_data_t;

endpackage

`default_nettype wire

// file: les_le_reg.sv
`include "les_params.svh"
`default_nettype none

module les_le_reg (
  input  wire logic clk_i,      // block clock
  input  wire logic sys_rst_i,  // synchronous reset
  input  wire logic aclr_i,     // block asynchronous clear
  input  wire logic en_i,       // block clock enable
  input  wire logic d_i,        // selected register input
  output var  logic q_o         // register output
);

  always_ff @(posedge clk_i or posedge aclr_i) begin
    if (aclr_i) begin
      q_o <= `LES_REG_RST;
    end else if (sys_rst_i) begin
      q_o <= `LES_REG_RST;
    end else if (en_i) begin
      q_o <= d_i;
    end
  end

  a_aclr_holds_zero : assert property (@(posedge clk_i)
    aclr_i && $past(aclr_i) |-> q_o == `LES_REG_RST)
    else $error("register not cleared by async clear");

  a_capture_on_edge : assert property (@(posedge clk_i)
    disable iff (sys_rst_i || aclr_i)
    en_i |=> q_o == $past(d_i))
    else $error("register missed its input on clock edge");

endmodule

`default_nettype wire

// file: les_nbr.sv
`default_nettype none

// register of the element above element 0, seen from the block's chain input
module les_nbr (
  input  wire logic        clk_i,    // block clock
  input  wire logic        load_i,   // take a new pattern
  input  wire logic [15:0] pat_i,    // pattern shifted out lsb first
  output var  logic        chain_o   // register chain into element 0
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] sh_r;

  // lsb re-enters inverted so the chain never settles into a constant
  always_ff @(posedge clk_i) begin
    if (load_i) begin
      sh_r <= pat_i;
    end else begin
      sh_r <= {~sh_r[0], sh_r[15:1]};
    end
  end

  assign chain_o = sh_r[0];
endmodule

`default_nettype wire

// file: tb_les_lab.sv
`include "les_params.svh"
`default_nettype none

module tb_les_lab;
  timeunit 1ns;
  timeprecision 1ps;
  import les_pkg::*;

  typedef struct {logic [9:0] ec; logic [9:0] er; logic [1:0] ey; logic cv;} les_note_t;

  logic                 clk_i     = 1'h0;
  logic                 sys_rst_i = 1'h1;
  logic                 aclr_i    = 1'h0;
  logic                 load      = 1'h1;
  les_ctrl_t            ctrl      = '0;
  les_cfg_t  [9:0]      cfg       = '0;
  les_data_t [9:0]      data      = '0;
  logic      [9:0]      comb_o;
  logic      [9:0]      reg_o;
  logic                 chain;
  logic                 co0, co1;
  logic      [10:0]     t0, t1;
  les_note_t            q[$];
  les_note_t            n;
  les_data_t [9:0]      dv;
  logic      [15:0]     mk[10];
  logic      [9:0]      a, b, ev, rexp, pc;
  logic                 s, ci, x;
  int                   src = 2;
  int                   i, k, cyc;
  int                   err_total, checked;

  always #5 clk_i = ~clk_i;

  les_nbr u_nbr (.clk_i(clk_i), .load_i(load), .pat_i(16'ha5c3), .chain_o(chain));

  les_lab u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .aclr_i(aclr_i), .ctrl_i(ctrl),
    .cfg_i(cfg), .data_i(data), .reg_chain_i(chain), .comb_o(comb_o), .reg_o(reg_o),
    .carry_out0_o(co0), .carry_out1_o(co1));

  task automatic chk(string nm, logic [9:0] seen, logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // expected register follows what the previous edge was told to do
  task automatic tick();
    @(posedge clk_i);
    if (src == 0) rexp = pc;
    else if (src == 1) rexp = {rexp[8:0], chain};
  endtask

  task automatic note(logic [9:0] ec, int nsrc, logic [1:0] ey = 2'h0, logic cv = 1'h0);
    q.push_back('{ec, rexp, ey, cv});
    pc = ec;
    src = nsrc;
  endtask

  always @(negedge clk_i) begin
    if (q.size() > 0) begin
      n = q.pop_front();
      chk("comb_o", comb_o, n.ec);
      chk("reg_o", reg_o, n.er);
      if (n.cv) chk("carry_o", {8'h00, co1, co0}, {8'h00, n.ey});
    end
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 200) begin
      err_total++;
      stop_test();
    end
  end

  initial begin
    void'($urandom(39767));
    rexp = 10'h000;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    load <= 1'h0;
    for (i = 0; i < 10; i++) cfg[i] <= '{LES_MODE_ARITH, 16'h0000, LES_SRC_LUT, 1'h0, 1'h0};
    for (k = 0; k < 16; k++) begin
      tick();
      a = 10'($urandom);
      b = 10'($urandom);
      s = k[0];
      ci = k[1];
      for (i = 0; i < 10; i++) dv[i] = {2'($urandom), b[i], a[i]};
      ctrl <= '{s, ci, 1'h1};
      data <= dv;
      // primary carry starts at the subtract bit, secondary at one
      t0 = {1'h0, a} + {1'h0, b ^ {10{s}}} + 11'(s);
      t1 = {1'h0, a} + {1'h0, b ^ {10{s}}} + 11'h001;
      note(a + (b ^ {10{s}}) + 10'(s | ci), 0, {t1[10], t0[10]}, 1'h1);
    end
    // lookup tables do unrelated work while registers shift
    for (i = 0; i < 10; i++) mk[i] = 16'($urandom);
    for (k = 0; k < 12; k++) begin
      tick();
      for (i = 0; i < 10; i++) dv[i] = 4'($urandom);
      for (i = 0; i < 10; i++) ev[i] = mk[i][dv[i]];
      for (i = 0; i < 10; i++) cfg[i] <= '{LES_MODE_NORMAL, mk[i], LES_SRC_CHAIN, 1'h0, 1'h0};
      data <= dv;
      note(ev, 1);
    end
    // own register through own table as an inverter: toggles each edge
    for (k = 0; k < 4; k++) begin
      tick();
      for (i = 0; i < 10; i++) cfg[i] <= '{LES_MODE_NORMAL, 16'h00ff, LES_SRC_LUT, 1'h1, 1'h0};
      note(~rexp, 0);
    end
    for (k = 0; k < 4; k++) begin
      tick();
      x = 1'($urandom);
      for (i = 0; i < 10; i++) dv[i] = 4'($urandom);
      dv[0][2] = x;
      for (i = 0; i < 10; i++) cfg[i] <= '{LES_MODE_NORMAL, 16'hf0f0, LES_SRC_LUT, 1'h0, 1'h1};
      ctrl <= '{1'h0, 1'h0, 1'h0};
      data <= dv;
      note({10{x}}, 2);
    end
    tick();
    aclr_i <= 1'h1;
    #1 chk("aclr", reg_o, 10'h000);
    tick();
    aclr_i <= 1'h0;
    rexp = 10'h000;
    note(pc, 2);
    repeat (2) tick();
    stop_test();
  end
endmodule

`default_nettype wire
